// *** core/edl_pkg.sv ***
package edl_pkg;
  // register byte offsets
  localparam logic [15:0] OFS_RX_WAKE = 16'h1008;
  localparam logic [15:0] OFS_RX_BASE = 16'h100C;
  localparam logic [15:0] OFS_TX_BASE = 16'h1010;
  localparam logic [15:0] OFS_STATUS = 16'h1014;
  localparam logic [15:0] OFS_CTRL = 16'h1018;
  localparam logic [15:0] OFS_MASK = 16'h101C;
  localparam logic [15:0] OFS_TX_WAKE = 16'h1020;
  localparam logic [15:0] OFS_RX_CUR = 16'h1024;
  localparam logic [15:0] OFS_TX_CUR = 16'h1028;
  // field positions
  localparam int BIT_TX_UNAVAIL = 2;
  localparam int BIT_RX_UNAVAIL = 7;
  localparam int LSB_RX_STATE = 17;
  localparam int LSB_TX_STATE = 20;
  localparam int BIT_RX_START = 1;
  localparam int BIT_TX_START = 13;
  // reset values and constants
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] DESC_STEP = 32'h0000_0010;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // process state codes
  localparam logic [2:0] PS_STOPPED = 3'h0;
  localparam logic [2:0] PS_FETCH = 3'h1;
  localparam logic [2:0] PS_RUN = 3'h3;
  localparam logic [2:0] PS_RX_SUSP = 3'h4;
  localparam logic [2:0] PS_TX_SUSP = 3'h6;

  typedef enum logic [3:0] {
    ENG_STOP = 4'h1,
    ENG_FETCH = 4'h2,
    ENG_RUN = 4'h4,
    ENG_SUSP = 4'h8
  } edl_eng_state_t;

  function automatic logic [31:0] edl_align(input logic [31:0] a);
    edl_align = a & ALIGN_MASK;
  endfunction : edl_align
endpackage : edl_pkg

// *** core/edl_desc_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module edl_desc_engine
  import edl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // commands
  input wire logic run,
  input wire logic poll,
  input wire logic done,
  input wire logic [31:0] base,
  // descriptor fetch
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic fetch_own,
  // state and events
  output edl_eng_state_t state,
  output logic unavail
);
  typedef struct packed {
    edl_eng_state_t st;
    logic [31:0] ptr;
    logic req;
    logic unavail;
  } edl_eng_q_t;

  edl_eng_q_t q_r;
  edl_eng_q_t q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.unavail = 1'b0;
    case (q_r.st)
      ENG_STOP:
      begin
        if (run)
        begin
          q_nxt.ptr = edl_align(base);
          q_nxt.st = ENG_FETCH;
          q_nxt.req = 1'b1;
        end
      end
      ENG_FETCH:
      begin
        if (fetch_ack)
        begin
          q_nxt.req = 1'b0;
          if (fetch_own)
            q_nxt.st = ENG_RUN;
          else
          begin
            // only cause of suspend
            q_nxt.st = ENG_SUSP;
            q_nxt.unavail = 1'b1;
          end
        end
      end
      ENG_RUN:
      begin
        if (done)
        begin
          q_nxt.ptr = q_r.ptr + DESC_STEP;
          q_nxt.st = ENG_FETCH;
          q_nxt.req = 1'b1;
        end
      end
      ENG_SUSP:
      begin
        // re-read the same descriptor
        if (poll)
        begin
          q_nxt.st = ENG_FETCH;
          q_nxt.req = 1'b1;
        end
      end
      default:
      begin
        q_nxt.st = ENG_STOP;
        q_nxt.req = 1'b0;
      end
    endcase
    if (!run)
    begin
      q_nxt.st = ENG_STOP;
      q_nxt.req = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q_r.st <= ENG_STOP;
      q_r.ptr <= BASE_RESET;
      q_r.req <= 1'b0;
      q_r.unavail <= 1'b0;
    end
    else
      q_r <= q_nxt;
  end

  assign fetch_req = q_r.req;
  assign fetch_addr = q_r.ptr;
  assign state = q_r.st;
  assign unavail = q_r.unavail;
endmodule : edl_desc_engine
`default_nettype wire

// *** core/edl_ahb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module edl_ahb_slave
  import edl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register side
  output logic rd_en,
  output logic [15:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [15:0] wr_addr
);
  typedef struct packed {
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic wpend;
    logic [15:0] waddr;
  } edl_slv_q_t;

  edl_slv_q_t q_r;
  edl_slv_q_t q_nxt;
  logic take;

  assign take = hsel && htrans == HTRANS_NONSEQ && hready;
  assign rd_en = take && !hwrite;
  assign rd_addr = haddr[15:0];

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.wpend = 1'b0;
    q_nxt.rdy = 1'b1;
    if (rd_en)
      q_nxt.rdata = rd_data;
    if (take && hwrite)
    begin
      // one wait state lets the write land before any later read
      q_nxt.wpend = 1'b1;
      q_nxt.rdy = 1'b0;
      q_nxt.waddr = haddr[15:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q_r.rdata <= 32'h0000_0000;
      q_r.rdy <= 1'b1;
      q_r.resp <= 1'b0;
      q_r.wpend <= 1'b0;
      q_r.waddr <= 16'h0000;
    end
    else
      q_r <= q_nxt;
  end

  assign hrdata = q_r.rdata;
  assign hreadyout = q_r.rdy;
  assign hresp = q_r.resp;
  assign wr_en = q_r.wpend;
  assign wr_addr = q_r.waddr;
endmodule : edl_ahb_slave
`default_nettype wire

// *** core/edl_top.sv ***
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module edl_top
  import edl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // interrupt
  output logic IRQ,
  // receive descriptor fetch
  output logic RX_FETCH_REQ,
  output logic [31:0] RX_FETCH_ADDR,
  input wire logic RX_FETCH_ACK,
  input wire logic RX_FETCH_OWN,
  input wire logic RX_DESC_DONE,
  // transmit descriptor fetch
  output logic TX_FETCH_REQ,
  output logic [31:0] TX_FETCH_ADDR,
  input wire logic TX_FETCH_ACK,
  input wire logic TX_FETCH_OWN,
  input wire logic TX_DESC_DONE
);
  typedef struct packed {
    logic [31:0] rx_base;
    logic [31:0] tx_base;
    logic rx_run;
    logic tx_run;
    logic rx_unav;
    logic tx_unav;
    logic msk_rx;
    logic msk_tx;
    logic irq;
  } edl_top_q_t;

  edl_top_q_t q_r;
  edl_top_q_t q_nxt;

  logic rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [15:0] wr_addr;
  logic rx_poll;
  logic tx_poll;
  logic rx_ev;
  logic tx_ev;
  logic [31:0] rx_cur;
  logic [31:0] tx_cur;
  edl_eng_state_t rx_st;
  edl_eng_state_t tx_st;

  // map engine state to the reported process code
  function automatic logic [2:0] edl_code(input edl_eng_state_t s,
                                          input logic [2:0] susp);
    case (s)
      ENG_FETCH: edl_code = PS_FETCH;
      ENG_RUN: edl_code = PS_RUN;
      ENG_SUSP: edl_code = susp;
      default: edl_code = PS_STOPPED;
    endcase
  endfunction : edl_code

  // hardware-managed bits of the status word
  function automatic logic [31:0] edl_stat(input logic rxb, input logic txb);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[BIT_RX_UNAVAIL] = rxb;
    v[BIT_TX_UNAVAIL] = txb;
    edl_stat = v;
  endfunction : edl_stat

  edl_ahb_slave u_slave (
    .clk(CLK),
    .rst_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hready(HREADY),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr)
  );

  // write of any value is the command; nothing is stored
  assign rx_poll = wr_en && wr_addr == OFS_RX_WAKE;
  assign tx_poll = wr_en && wr_addr == OFS_TX_WAKE;

  edl_desc_engine u_rx (
    .clk(CLK),
    .rst_n(RST_N),
    .run(q_r.rx_run),
    .poll(rx_poll),
    .done(RX_DESC_DONE),
    .base(q_r.rx_base),
    .fetch_req(RX_FETCH_REQ),
    .fetch_addr(rx_cur),
    .fetch_ack(RX_FETCH_ACK),
    .fetch_own(RX_FETCH_OWN),
    .state(rx_st),
    .unavail(rx_ev)
  );

  edl_desc_engine u_tx (
    .clk(CLK),
    .rst_n(RST_N),
    .run(q_r.tx_run),
    .poll(tx_poll),
    .done(TX_DESC_DONE),
    .base(q_r.tx_base),
    .fetch_req(TX_FETCH_REQ),
    .fetch_addr(tx_cur),
    .fetch_ack(TX_FETCH_ACK),
    .fetch_own(TX_FETCH_OWN),
    .state(tx_st),
    .unavail(tx_ev)
  );

  assign RX_FETCH_ADDR = rx_cur;
  assign TX_FETCH_ADDR = tx_cur;

  // read mux; wake-up registers read as zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFS_RX_BASE: rd_data = q_r.rx_base;
      OFS_TX_BASE: rd_data = q_r.tx_base;
      OFS_STATUS:
      begin
        rd_data = edl_stat(q_r.rx_unav, q_r.tx_unav);
        rd_data[LSB_RX_STATE +: 3] = edl_code(rx_st, PS_RX_SUSP);
        rd_data[LSB_TX_STATE +: 3] = edl_code(tx_st, PS_TX_SUSP);
      end
      OFS_CTRL:
      begin
        rd_data[BIT_RX_START] = q_r.rx_run;
        rd_data[BIT_TX_START] = q_r.tx_run;
      end
      OFS_MASK: rd_data = edl_stat(q_r.msk_rx, q_r.msk_tx);
      OFS_RX_CUR: rd_data = rx_cur;
      OFS_TX_CUR: rd_data = tx_cur;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    q_nxt = q_r;
    if (wr_en)
    begin
      case (wr_addr)
        // bits 1:0 never stored, so they read back as zero
        OFS_RX_BASE: q_nxt.rx_base = edl_align(HWDATA);
        OFS_TX_BASE: q_nxt.tx_base = edl_align(HWDATA);
        OFS_CTRL:
        begin
          q_nxt.rx_run = HWDATA[BIT_RX_START];
          q_nxt.tx_run = HWDATA[BIT_TX_START];
        end
        OFS_MASK:
        begin
          q_nxt.msk_rx = HWDATA[BIT_RX_UNAVAIL];
          q_nxt.msk_tx = HWDATA[BIT_TX_UNAVAIL];
        end
        default:
        begin
        end
      endcase
    end
    // read clears, but an event in the same cycle wins
    if (rd_en && rd_addr == OFS_STATUS)
    begin
      q_nxt.rx_unav = 1'b0;
      q_nxt.tx_unav = 1'b0;
    end
    if (rx_ev)
      q_nxt.rx_unav = 1'b1;
    if (tx_ev)
      q_nxt.tx_unav = 1'b1;
    q_nxt.irq = (q_nxt.rx_unav && q_nxt.msk_rx) ||
                (q_nxt.tx_unav && q_nxt.msk_tx);
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      q_r.rx_base <= BASE_RESET;
      q_r.tx_base <= BASE_RESET;
      q_r.rx_run <= 1'b0;
      q_r.tx_run <= 1'b0;
      q_r.rx_unav <= 1'b0;
      q_r.tx_unav <= 1'b0;
      q_r.msk_rx <= 1'b0;
      q_r.msk_tx <= 1'b0;
      q_r.irq <= 1'b0;
    end
    else
      q_r <= q_nxt;
  end

  assign IRQ = q_r.irq;
endmodule : edl_top
`default_nettype wire

// *** tb/edl_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module edl_mem
(
  // fetch link
  input wire logic clk,
  input wire logic req,
  input wire logic own_cfg,
  input wire logic [1:0] lat,
  output logic ack,
  output logic own
);
  logic ack_r = 1'b0;
  logic pat_r = 1'b0;
  logic [1:0] cnt_r = 2'h0;
  assign ack = ack_r;
  // owner flag is only valid with ack; it churns so no stale value is read
  assign own = ack_r ? own_cfg : pat_r;
  always_ff @(posedge clk)
  begin
    pat_r <= ~pat_r;
    if (!req || ack_r)
    begin
      ack_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (cnt_r == lat)
      ack_r <= 1'b1;
    else
      cnt_r <= cnt_r + 2'h1;
  end
endmodule : edl_mem
`default_nettype wire

// *** tb/edl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module edl_chk
  import edl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  // fetch
  input wire logic RX_FETCH_REQ,
  input wire logic [31:0] RX_FETCH_ADDR,
  input wire logic RX_FETCH_ACK,
  input wire logic RX_FETCH_OWN,
  input wire logic TX_FETCH_REQ,
  input wire logic [31:0] TX_FETCH_ADDR,
  input wire logic TX_FETCH_ACK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic rx_susp_r;
  wire logic tk = HSEL && HTRANS == HTRANS_NONSEQ && HREADY;
  wire logic [15:0] ofs = HADDR[15:0];
  // wake-up only acts in suspend, so track it from the fetch answers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rx_susp_r <= 1'b0;
    else if (RX_FETCH_REQ && RX_FETCH_ACK)
      rx_susp_r <= !RX_FETCH_OWN;
  end
  property p_rx_align;
    RX_FETCH_REQ |-> RX_FETCH_ADDR[1:0] == 2'h0;
  endproperty
  a_rx_align: assert property (p_rx_align) else $error("rx addr");
  property p_tx_align;
    TX_FETCH_REQ |-> TX_FETCH_ADDR[1:0] == 2'h0;
  endproperty
  a_tx_align: assert property (p_tx_align) else $error("tx addr");
  property p_rx_hold;
    RX_FETCH_REQ && !RX_FETCH_ACK |=> !RX_FETCH_REQ || $stable(RX_FETCH_ADDR);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx moved");
  property p_rx_end;
    RX_FETCH_REQ && RX_FETCH_ACK |=> !RX_FETCH_REQ;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx req");
  property p_tx_end;
    TX_FETCH_REQ && TX_FETCH_ACK |=> !TX_FETCH_REQ;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx req");
  property p_wr_wait;
    tk && HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("wait");
  property p_low_zero;
    tk && !HWRITE && (ofs == OFS_RX_BASE || ofs == OFS_TX_BASE)
      |=> HRDATA[1:0] == 2'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits");
  property p_rx_wake;
    tk && HWRITE && ofs == OFS_RX_WAKE && rx_susp_r |-> ##[2:4] RX_FETCH_REQ;
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("no refetch");
  c_rx_susp: cover property (RX_FETCH_ACK && !RX_FETCH_OWN);
  c_rx_run: cover property (RX_FETCH_ACK && RX_FETCH_OWN);
  c_tx_ack: cover property (TX_FETCH_REQ && TX_FETCH_ACK);
endmodule : edl_chk
bind edl_top edl_chk u_chk (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import edl_pkg::*;
;
  logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, RX_FETCH_ADDR, TX_FETCH_ADDR;
  logic [1:0] HTRANS = '0, lat = '0;
  logic [2:0] HSIZE = 3'h2;
  logic RX_DESC_DONE = 1'b0, TX_DESC_DONE = 1'b0, rx_own = 1'b0;
  logic tx_own = 1'b0, HREADYOUT, HRESP, IRQ, RX_FETCH_REQ, TX_FETCH_REQ;
  logic RX_FETCH_ACK, RX_FETCH_OWN, TX_FETCH_ACK, TX_FETCH_OWN;
  wire logic HREADY = HREADYOUT;
  integer seed = 87, num_errors = 0, tests_run = 0, k;
  logic [31:0] d, v, rxb, txb;
  localparam logic [31:0] SM = 32'h007E_0084;
  edl_top dut (.*);
  edl_mem u_rxm (.clk(CLK), .req(RX_FETCH_REQ), .own_cfg(rx_own), .lat(lat),
    .ack(RX_FETCH_ACK), .own(RX_FETCH_OWN));
  edl_mem u_txm (.clk(CLK), .req(TX_FETCH_REQ), .own_cfg(tx_own), .lat(lat),
    .ack(TX_FETCH_ACK), .own(TX_FETCH_OWN));
  initial
  begin
    forever #20 CLK = ~CLK;
  end
  function automatic logic [31:0] st(input logic [2:0] rs, input logic [2:0] ts,
    input logic ru, input logic tu);
    return {9'h0, ts, rs, 9'h0, ru, 4'h0, tu, 2'h0};
  endfunction : st
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one word per transfer; address phase held until ready is seen
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {16'h0, a};
    do @(posedge CLK); while (!HREADY);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (!HREADY);
    d = HRDATA;
  endtask : xfer
  task wr(input logic [15:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr
  task rd(input logic [15:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task idle;
    repeat (2) @(posedge CLK);
    for (k = 0; k < 40 && (RX_FETCH_REQ || TX_FETCH_REQ); k++)
      @(posedge CLK);
    // sticky bits and irq land one edge after the request drops
    repeat (2) @(posedge CLK);
  endtask : idle
  task give_verdict;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (3000) @(posedge CLK);
    num_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    rd(OFS_RX_BASE);
    chk(d, BASE_RESET);
    rd(OFS_TX_BASE);
    chk(d, BASE_RESET);
    rd(16'h1100);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      wr(OFS_RX_BASE, v);
      wr(OFS_TX_BASE, ~v);
      rd(OFS_RX_BASE);
      chk(d, v & ALIGN_MASK);
      rd(OFS_TX_BASE);
      chk(d, ~v & ALIGN_MASK);
    end
    rxb = $random(seed) & ALIGN_MASK;
    txb = $random(seed) & ALIGN_MASK;
    wr(OFS_RX_BASE, rxb);
    wr(OFS_TX_BASE, txb);
    wr(OFS_MASK, 32'h0000_0084);
    lat <= 2'($random(seed));
    wr(OFS_CTRL, 32'h0000_2002);
    idle;
    chk(RX_FETCH_ADDR, rxb);
    chk(TX_FETCH_ADDR, txb);
    chk({31'h0, IRQ}, 32'h1);
    rd(OFS_STATUS);
    chk(d & SM, st(3'h4, 3'h6, 1'b1, 1'b1));
    rd(OFS_STATUS);
    chk(d & SM, st(3'h4, 3'h6, 1'b0, 1'b0));
    chk({31'h0, IRQ}, 32'h0);
    rx_own <= 1'b1;
    wr(OFS_RX_WAKE, $random(seed));
    chk({31'h0, HRESP}, 32'h0);
    wr(OFS_TX_WAKE, $random(seed));
    idle;
    chk(RX_FETCH_ADDR, rxb);
    rd(OFS_STATUS);
    chk(d & SM, st(3'h3, 3'h6, 1'b0, 1'b1));
    tx_own <= 1'b1;
    wr(OFS_TX_WAKE, 32'h0);
    RX_DESC_DONE <= 1'b1;
    @(posedge CLK);
    RX_DESC_DONE <= 1'b0;
    idle;
    rd(OFS_RX_CUR);
    chk(d, rxb + DESC_STEP);
    // transmit must be running again before done counts
    TX_DESC_DONE <= 1'b1;
    @(posedge CLK);
    TX_DESC_DONE <= 1'b0;
    idle;
    rd(OFS_TX_CUR);
    chk(d, txb + DESC_STEP);
    rd(OFS_STATUS);
    chk(d & SM, st(3'h3, 3'h3, 1'b0, 1'b0));
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
